// ---- hdl/ddc_pkg.sv ----
// Shared constants, types and helpers of the multichannel decimation chain
package ddc_pkg;

    // --------------------
    // Stream geometry
    // --------------------
    localparam int SAMPLE_W     = 14;          // Antenna sample width, 13 fraction bits
    localparam int CHAN_IDX_W   = 8;           // Input channel tag width
    localparam int CH_COUNT     = 16;          // Channels on the output wire
    localparam int CHAN_W       = 4;           // Bits kept of a channel tag
    localparam int VEC_ELEMS    = 4;           // Elements of the CIC input vector
    localparam int CH_PER_ELEM  = 4;           // Channels carried per element
    localparam int SMP_W        = 16;          // Stream sample width, 15 fraction bits
    localparam int ACC_W        = 48;          // Wide arithmetic width

    // --------------------
    // CIC decimator
    // --------------------
    localparam int CIC_STAGES     = 5;
    localparam int CIC_DECIM      = 16;
    localparam int DEC_CNT_W      = 4;
    localparam int CIC_DIFF_DELAY = 1;         // Customary comb delay
    localparam int CIC_MAX_DELAY  = 4;
    localparam int CIC_GAIN       = 1048576;   // (16*1)^5
    localparam int CIC_GROWTH     = 20;        // log2 of the gain
    localparam int CIC_W          = SAMPLE_W + CIC_GROWTH;
    localparam int CIC_SHIFT_LEFT = -20;       // Static shift cancelling the gain
    localparam int CIC_VAR_SHIFT  = 0;         // Variable shift input, tied off
    localparam int FRAC_ADJ       = 2;         // 13 to 15 fraction bits
    localparam int CIC_RIGHT_SHIFT = -(CIC_SHIFT_LEFT + CIC_VAR_SHIFT + FRAC_ADJ);

    // --------------------
    // FIR decimators and coefficient port
    // --------------------
    localparam int FIR_DECIM       = 4;
    localparam int PHASE_W         = 2;
    localparam int FIR1_TAPS       = 21;
    localparam int FIR2_TAPS       = 63;
    localparam int COEF_W          = 16;
    localparam int COEF_FRAC       = 15;
    localparam int COEF_ADDR_W     = 8;
    localparam logic [7:0] FIR1_COEF_BASE = 8'h00;
    localparam logic [7:0] FIR2_COEF_BASE = 8'h20;
    localparam logic [15:0] COEF_CENTRE_RESET = 16'h7fff;  // Near-unity centre tap

    // --------------------
    // Types
    // --------------------
    typedef logic signed [CIC_W-1:0]  ddc_cic_t;
    typedef logic signed [SMP_W-1:0]  ddc_smp_t;
    typedef logic signed [COEF_W-1:0] ddc_coef_t;
    typedef logic signed [ACC_W-1:0]  ddc_acc_t;

    typedef struct packed {
        logic                          valid;
        logic [CHAN_IDX_W-1:0]         chan;
        logic signed [SAMPLE_W-1:0]    prim;
        logic signed [SAMPLE_W-1:0]    div;
    } ddc_in_s;

    typedef struct packed {
        logic              valid;
        logic [CHAN_W-1:0] chan;
        ddc_smp_t          data;
    } ddc_stream_s;

    // Saturate a wide value to the stream sample width
    function automatic ddc_smp_t ddc_sat(input ddc_acc_t v);
        ddc_smp_t r;
        r = 16'sh0000;
        if (v > 48'sh0000_0000_7fff)
            r = 16'sh7fff;
        else if (v < -48'sh0000_0000_8000)
            r = 16'sh8000;
        else
            r = v[SMP_W-1:0];
        return r;
    endfunction

endpackage

// ---- hdl/ddc_downconverter_top.sv ----
// Decimation chain: CIC by 16, static scaler, two decimate-by-4 FIRs with scalers
//
// Summary of operation
// - Five-stage CIC decimates each channel by 16
// - Comb delay depth set by a parameter, default one
// - Four independent CICs, four channels each
// - Merge element one channels first, then element two
// - Bursts of sixteen valid samples, channels 0..15
// - CIC output wire busy one cycle in four
// - Integrators at input rate, one shared comb section
// - CIC gain two to the twentieth
// - Static minus twenty shift, variable shift tied zero
// - First FIR decimates by four using symmetry
// - Coefficients signed 16 bits, 15 fraction bits
// - First FIR: input per 64, output per 256
// - Coefficients written by processor at mapped addresses
// - Second FIR: 63 taps, further decimation
// - CIC has no writable registers or addresses
// - Channel tag 8 bits, upper bits dropped
// - Each stage starts on its incoming valid
// - Data genuine only while valid is high
`timescale 1ns/1ps

module ddc_downconverter_top
    import ddc_pkg::*;
#(
    parameter int DIFF_DELAY = CIC_DIFF_DELAY,   // Comb differential delay
    parameter int F1_TAPS    = FIR1_TAPS,        // First FIR length, odd
    parameter int F2_TAPS    = FIR2_TAPS         // Second FIR length, odd
)(
    input  wire logic                          I_SYS_CLK,
    input  wire logic                          I_RESET,
    input  wire logic signed [SAMPLE_W-1:0]    I_PRIMARY_ANTENNA_SAMPLE,
    input  wire logic signed [SAMPLE_W-1:0]    I_DIVERSITY_ANTENNA_SAMPLE,
    input  wire logic [CHAN_IDX_W-1:0]         I_INPUT_CHANNEL_INDEX,
    input  wire logic                          I_INPUT_SAMPLE_VALID,
    input  wire logic                          I_COEF_WRITE,
    input  wire logic [COEF_ADDR_W-1:0]        I_COEF_ADDR,
    input  wire logic [COEF_W-1:0]             I_COEF_DATA,
    output logic                               O_CIC_VALID,
    output logic [CHAN_W-1:0]                  O_CIC_CHANNEL,
    output logic signed [SMP_W-1:0]            O_CIC_SAMPLE,
    output logic                               O_OUT_VALID,
    output logic [CHAN_W-1:0]                  O_OUT_CHANNEL,
    output logic signed [SMP_W-1:0]            O_OUT_SAMPLE
);

    // --------------------
    // Derived sizes and elaboration checks
    // --------------------
    localparam int NC1 = (F1_TAPS + 1) / 2;    // Stored half of first FIR
    localparam int NC2 = (F2_TAPS + 1) / 2;    // Stored half of second FIR

    // Symmetric storage needs odd lengths; banks must not overlap
    if (F1_TAPS % 2 == 0 || F2_TAPS % 2 == 0 || F1_TAPS < 3 || F2_TAPS < 3)
        $error("FIR lengths must be odd and at least 3");
    if (NC1 > int'(FIR2_COEF_BASE - FIR1_COEF_BASE) || NC2 > 256 - int'(FIR2_COEF_BASE))
        $error("Coefficient banks do not fit the address space");
    if (DIFF_DELAY < 1 || DIFF_DELAY > CIC_MAX_DELAY)
        $error("Comb differential delay out of range");

    // --------------------
    // State of the whole chain
    // --------------------
    typedef struct packed {
        ddc_in_s                                                sync1;     // First pin stage
        ddc_in_s                                                sync2;     // Second pin stage
        ddc_cic_t [VEC_ELEMS-1:0][CH_PER_ELEM-1:0][CIC_STAGES-1:0] integ; // Integrators
        logic [CH_PER_ELEM-1:0][DEC_CNT_W-1:0]                  dec_cnt;   // Decimation phase
        ddc_cic_t [CH_COUNT-1:0]                                snap;      // Decimated values
        logic                                                   burst_act; // Burst running
        logic [CHAN_W-1:0]                                      burst_idx; // Burst channel
        ddc_cic_t [CH_COUNT-1:0][CIC_STAGES-1:0][DIFF_DELAY-1:0] comb_dly; // Comb memory
        logic                                                   cic_raw_valid;
        logic [CHAN_W-1:0]                                      cic_raw_chan;
        ddc_cic_t                                               cic_raw;   // Full-width comb out
        ddc_stream_s                                            cic_out;   // Scaled CIC stream
        ddc_smp_t [CH_COUNT-1:0][F1_TAPS-1:0]                   f1_hist;   // First FIR lines
        logic [CH_COUNT-1:0][PHASE_W-1:0]                       f1_phase;
        ddc_coef_t [NC1-1:0]                                    f1_coef;
        logic                                                   f1_acc_valid;
        logic [CHAN_W-1:0]                                      f1_acc_chan;
        ddc_acc_t                                               f1_acc;
        ddc_stream_s                                            f1_out;    // Scaled first FIR
        ddc_smp_t [CH_COUNT-1:0][F2_TAPS-1:0]                   f2_hist;   // Second FIR lines
        logic [CH_COUNT-1:0][PHASE_W-1:0]                       f2_phase;
        ddc_coef_t [NC2-1:0]                                    f2_coef;
        logic                                                   f2_acc_valid;
        logic [CHAN_W-1:0]                                      f2_acc_chan;
        ddc_acc_t                                               f2_acc;
        ddc_stream_s                                            f2_out;    // Scaled second FIR
    } ddc_state_s;

    // Reset image: all clear, each FIR a near-unity impulse at its centre tap
    function automatic ddc_state_s ddc_reset_image();
        ddc_state_s r;
        r = '0;
        r.f1_coef[NC1-1] = COEF_CENTRE_RESET;
        r.f2_coef[NC2-1] = COEF_CENTRE_RESET;
        return r;
    endfunction

    localparam ddc_state_s ST_RESET = ddc_reset_image();

    ddc_state_s st;        // Registered state
    ddc_state_s next_st;   // Next state

    // --------------------
    // Next-state logic
    // --------------------
    // One pass per clock through sync, CIC, scaler and both FIRs
    always_comb
    begin
        ddc_cic_t x;
        ddc_cic_t y;
        ddc_cic_t t;
        ddc_acc_t acc;
        int       ch;
        int       c;
        int       idx;
        x   = '0;
        y   = '0;
        t   = '0;
        acc = '0;
        ch  = 0;
        c   = 0;
        idx = 0;
        next_st = st;

        // Pin capture: both stages free-running, second stage alone feeds logic
        next_st.sync1.valid = I_INPUT_SAMPLE_VALID;
        next_st.sync1.chan  = I_INPUT_CHANNEL_INDEX;
        next_st.sync1.prim  = I_PRIMARY_ANTENNA_SAMPLE;
        next_st.sync1.div   = I_DIVERSITY_ANTENNA_SAMPLE;
        next_st.sync2       = st.sync1;

        // Integrators run at the input rate, one bank per vector element
        if (st.sync2.valid)
        begin
            ch = int'(st.sync2.chan[1:0]);
            for (int e = 0; e < VEC_ELEMS; e++)
            begin
                // Elements 0/2 carry the primary stream, 1/3 the diversity one
                x = (e % 2 == 0) ? CIC_W'(st.sync2.prim) : CIC_W'(st.sync2.div);
                next_st.integ[e][ch][0] = st.integ[e][ch][0] + x;
                for (int s = 1; s < CIC_STAGES; s++)
                    next_st.integ[e][ch][s] = st.integ[e][ch][s] + st.integ[e][ch][s-1];
                // Every sixteenth sample of a channel is kept for the comb
                if (st.dec_cnt[ch] == DEC_CNT_W'(CIC_DECIM - 1))
                    next_st.snap[e * CH_PER_ELEM + ch] = next_st.integ[e][ch][CIC_STAGES-1];
            end
            next_st.dec_cnt[ch] = st.dec_cnt[ch] + DEC_CNT_W'(1);
            // Last channel of a round decimated: all sixteen values are ready
            if (st.dec_cnt[ch] == DEC_CNT_W'(CIC_DECIM - 1) && ch == CH_PER_ELEM - 1)
            begin
                next_st.burst_act = 1'b1;
                next_st.burst_idx = '0;
            end
        end

        // Shared comb section walks the sixteen channels back to back
        next_st.cic_raw_valid = 1'b0;
        if (st.burst_act)
        begin
            idx = int'(st.burst_idx);
            y   = st.snap[idx];
            for (int s = 0; s < CIC_STAGES; s++)
            begin
                t = y - st.comb_dly[idx][s][DIFF_DELAY-1];
                for (int m = DIFF_DELAY - 1; m > 0; m--)
                    next_st.comb_dly[idx][s][m] = st.comb_dly[idx][s][m-1];
                next_st.comb_dly[idx][s][0] = y;
                y = t;
            end
            next_st.cic_raw_valid = 1'b1;
            next_st.cic_raw_chan  = st.burst_idx;
            next_st.cic_raw       = y;
            next_st.burst_idx     = st.burst_idx + CHAN_W'(1);
            if (st.burst_idx == CHAN_W'(CH_COUNT - 1))
                next_st.burst_act = 1'b0;
        end

        // Static scaler behind the CIC: fixed shift, result registered in cic_out
        next_st.cic_out.valid = st.cic_raw_valid;
        if (st.cic_raw_valid)
        begin
            next_st.cic_out.chan = st.cic_raw_chan;
            next_st.cic_out.data = ddc_sat(ACC_W'(st.cic_raw) >>> CIC_RIGHT_SHIFT);
        end

        // Coefficient writes from the processor side, one word per tap pair
        if (I_COEF_WRITE)
        begin
            if (I_COEF_ADDR >= FIR1_COEF_BASE && I_COEF_ADDR < FIR1_COEF_BASE + 8'(NC1))
                next_st.f1_coef[int'(I_COEF_ADDR - FIR1_COEF_BASE)] = I_COEF_DATA;
            if (I_COEF_ADDR >= FIR2_COEF_BASE && I_COEF_ADDR < FIR2_COEF_BASE + 8'(NC2))
                next_st.f2_coef[int'(I_COEF_ADDR - FIR2_COEF_BASE)] = I_COEF_DATA;
        end

        // First FIR: per-channel delay line, one output per four inputs
        next_st.f1_acc_valid = 1'b0;
        if (st.cic_out.valid)
        begin
            c = int'(st.cic_out.chan);
            for (int k = F1_TAPS - 1; k > 0; k--)
                next_st.f1_hist[c][k] = st.f1_hist[c][k-1];
            next_st.f1_hist[c][0] = st.cic_out.data;
            next_st.f1_phase[c]   = st.f1_phase[c] + PHASE_W'(1);
            if (st.f1_phase[c] == PHASE_W'(FIR_DECIM - 1))
            begin
                // Mirrored taps are pre-added so only half the products remain
                acc = '0;
                for (int k = 0; k < NC1 - 1; k++)
                    acc = acc + ACC_W'(st.f1_coef[k]) *
                          (ACC_W'(next_st.f1_hist[c][k]) +
                           ACC_W'(next_st.f1_hist[c][F1_TAPS-1-k]));
                acc = acc + ACC_W'(st.f1_coef[NC1-1]) * ACC_W'(next_st.f1_hist[c][NC1-1]);
                next_st.f1_acc_valid = 1'b1;
                next_st.f1_acc_chan  = st.cic_out.chan;
                next_st.f1_acc       = acc;
            end
        end

        // Scaler behind the first FIR drops the coefficient fraction
        next_st.f1_out.valid = st.f1_acc_valid;
        if (st.f1_acc_valid)
        begin
            next_st.f1_out.chan = st.f1_acc_chan;
            next_st.f1_out.data = ddc_sat(st.f1_acc >>> COEF_FRAC);
        end

        // Second FIR: same structure with the longer low-pass
        next_st.f2_acc_valid = 1'b0;
        if (st.f1_out.valid)
        begin
            c = int'(st.f1_out.chan);
            for (int k = F2_TAPS - 1; k > 0; k--)
                next_st.f2_hist[c][k] = st.f2_hist[c][k-1];
            next_st.f2_hist[c][0] = st.f1_out.data;
            next_st.f2_phase[c]   = st.f2_phase[c] + PHASE_W'(1);
            if (st.f2_phase[c] == PHASE_W'(FIR_DECIM - 1))
            begin
                acc = '0;
                for (int k = 0; k < NC2 - 1; k++)
                    acc = acc + ACC_W'(st.f2_coef[k]) *
                          (ACC_W'(next_st.f2_hist[c][k]) +
                           ACC_W'(next_st.f2_hist[c][F2_TAPS-1-k]));
                acc = acc + ACC_W'(st.f2_coef[NC2-1]) * ACC_W'(next_st.f2_hist[c][NC2-1]);
                next_st.f2_acc_valid = 1'b1;
                next_st.f2_acc_chan  = st.f1_out.chan;
                next_st.f2_acc       = acc;
            end
        end

        // Scaler behind the second FIR
        next_st.f2_out.valid = st.f2_acc_valid;
        if (st.f2_acc_valid)
        begin
            next_st.f2_out.chan = st.f2_acc_chan;
            next_st.f2_out.data = ddc_sat(st.f2_acc >>> COEF_FRAC);
        end
    end

    // --------------------
    // State register
    // --------------------
    // Reset clears every valid and accumulator; coefficients fall back
    always_ff @(posedge I_SYS_CLK or posedge I_RESET)
    begin
        if (I_RESET)
            st <= ST_RESET;
        else
            st <= next_st;
    end

    // --------------------
    // Outputs, each straight from the state register
    // --------------------
    assign O_CIC_VALID   = st.cic_out.valid;
    assign O_CIC_CHANNEL = st.cic_out.chan;
    assign O_CIC_SAMPLE  = st.cic_out.data;
    assign O_OUT_VALID   = st.f2_out.valid;
    assign O_OUT_CHANNEL = st.f2_out.chan;
    assign O_OUT_SAMPLE  = st.f2_out.data;

endmodule // ddc_downconverter_top

// ---- verification/ddc_chain_sva.sv ----
// Concurrent checks on the output streams of the decimation chain
`timescale 1ns/1ps

module ddc_chain_sva
    import ddc_pkg::*;
(
    input wire logic              I_SYS_CLK,
    input wire logic              I_RESET,
    input wire logic              I_INPUT_SAMPLE_VALID,
    input wire logic              I_COEF_WRITE,
    input wire logic              O_CIC_VALID,
    input wire logic [CHAN_W-1:0] O_CIC_CHANNEL,
    input wire logic              O_OUT_VALID,
    input wire logic [CHAN_W-1:0] O_OUT_CHANNEL
);
    // --------------------
    // Helper counters
    // --------------------
    logic [5:0]  cic_run;   // Valid cycles so far in this burst
    logic [5:0]  cic_idle;  // Idle cycles since the last burst
    logic [10:0] out_idle;  // Idle cycles since the last output
    logic        cic_seen;  // A burst has finished since reset
    logic        out_seen;  // An output has appeared since reset
    logic        in_seen;   // An input sample arrived since reset

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);

    // Idle counters saturate so a long stall cannot wrap into a match
    always_ff @(posedge I_SYS_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            cic_run  <= 6'h00;
            cic_idle <= 6'h00;
            out_idle <= 11'h000;
            cic_seen <= 1'b0;
            out_seen <= 1'b0;
            in_seen  <= 1'b0;
        end
        else
        begin
            cic_run  <= O_CIC_VALID ? cic_run + 6'h01 : 6'h00;
            cic_idle <= O_CIC_VALID ? 6'h00 : cic_idle + {5'h00, ~&cic_idle};
            out_idle <= O_OUT_VALID ? 11'h000 : out_idle + {10'h000, ~&out_idle};
            cic_seen <= cic_seen | (!O_CIC_VALID && cic_run != 6'h00);
            out_seen <= out_seen | O_OUT_VALID;
            in_seen  <= in_seen | I_INPUT_SAMPLE_VALID;
        end
    end

    // --------------------
    // Properties
    // --------------------
    property p_reset_quiet;
        disable iff (1'b0) I_RESET |-> !O_CIC_VALID && !O_OUT_VALID;
    endproperty
    property p_cic_burst_len; $fell(O_CIC_VALID) |-> cic_run == 6'h10; endproperty
    property p_cic_burst_max; O_CIC_VALID |-> cic_run < 6'h10; endproperty
    property p_cic_first_chan; $rose(O_CIC_VALID) |-> O_CIC_CHANNEL == 4'h0; endproperty
    property p_cic_chan_step;
        O_CIC_VALID && $past(O_CIC_VALID) |-> O_CIC_CHANNEL == $past(O_CIC_CHANNEL) + 4'h1;
    endproperty
    property p_cic_gap; $rose(O_CIC_VALID) && cic_seen |-> cic_idle == 6'h30; endproperty
    property p_cic_needs_input; O_CIC_VALID |-> in_seen; endproperty
    property p_out_first_chan; $rose(O_OUT_VALID) |-> O_OUT_CHANNEL == 4'h0; endproperty
    property p_out_chan_step;
        O_OUT_VALID && $past(O_OUT_VALID) |-> O_OUT_CHANNEL == $past(O_OUT_CHANNEL) + 4'h1;
    endproperty
    property p_out_spacing; $rose(O_OUT_VALID) && out_seen |-> out_idle == 11'h3f0; endproperty
    property p_out_needs_cic; O_OUT_VALID |-> cic_seen; endproperty

    a_reset_quiet: assert property (p_reset_quiet)
        else $error("valid seen during reset");
    a_cic_burst_len: assert property (p_cic_burst_len)
        else $error("cic burst not sixteen long");
    a_cic_burst_max: assert property (p_cic_burst_max)
        else $error("cic burst too long");
    a_cic_first_chan: assert property (p_cic_first_chan)
        else $error("cic burst not starting at channel zero");
    a_cic_chan_step: assert property (p_cic_chan_step)
        else $error("cic channel out of order");
    a_cic_gap: assert property (p_cic_gap)
        else $error("cic idle gap wrong");
    a_cic_needs_input: assert property (p_cic_needs_input)
        else $error("cic output without input");
    a_out_first_chan: assert property (p_out_first_chan)
        else $error("output burst not starting at channel zero");
    a_out_chan_step: assert property (p_out_chan_step)
        else $error("output channel out of order");
    a_out_spacing: assert property (p_out_spacing)
        else $error("output spacing wrong");
    a_out_needs_cic: assert property (p_out_needs_cic)
        else $error("output before any cic burst");

    c_cic_burst: cover property ($fell(O_CIC_VALID));
    c_out_burst: cover property ($rose(O_OUT_VALID));
    c_coef_write: cover property (I_COEF_WRITE);
endmodule // ddc_chain_sva

bind ddc_downconverter_top ddc_chain_sva chk_u (
    .I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET),
    .I_INPUT_SAMPLE_VALID(I_INPUT_SAMPLE_VALID), .I_COEF_WRITE(I_COEF_WRITE),
    .O_CIC_VALID(O_CIC_VALID), .O_CIC_CHANNEL(O_CIC_CHANNEL),
    .O_OUT_VALID(O_OUT_VALID), .O_OUT_CHANNEL(O_OUT_CHANNEL));

// ---- verification/ddc_adc_source.sv ----
// Converter-side model: two antenna streams with cycling channel tags
`timescale 1ns/1ps

module ddc_adc_source
    import ddc_pkg::*;
(
    input  wire logic                       i_clk,
    input  wire logic                       i_run,    // Stream on while high
    input  wire logic signed [SAMPLE_W-1:0] i_prim,   // Primary antenna level
    input  wire logic signed [SAMPLE_W-1:0] i_div,    // Diversity antenna level
    output ddc_in_s                         o_stream  // Pins toward the chain
);
    logic [1:0] tag;  // Channel within a vector element

    initial
    begin
        o_stream = '0;
        tag = 2'h0;
    end

    // Drive just after each edge; tags run 0,1,2,3 with no holes
    always @(posedge i_clk)
    begin
        #2;
        if (i_run)
        begin
            o_stream.valid <= 1'b1;
            o_stream.chan  <= {6'h2a, tag};
            o_stream.prim  <= i_prim;
            o_stream.div   <= i_div;
            tag <= tag + 2'h1;
        end
        else
        begin
            // Idle: flip data so a stale word cannot pass for a sample
            o_stream.valid <= 1'b0;
            o_stream.prim  <= ~o_stream.prim;
            o_stream.div   <= ~o_stream.div;
            tag <= 2'h0;
        end
    end
endmodule // ddc_adc_source

// ---- verification/tb_top.sv ----
// Self-checking bench of the decimation chain
`timescale 1ns/1ps

module tb_top
    import ddc_pkg::*;
;
    localparam logic signed [SAMPLE_W-1:0] PRIM = 14'sh0800;  // +0.25
    localparam logic signed [SAMPLE_W-1:0] DIV  = 14'sh3c00;  // -0.125

    logic                    I_SYS_CLK;
    logic                    I_RESET;
    logic                    I_COEF_WRITE;
    logic [COEF_ADDR_W-1:0]  I_COEF_ADDR;
    logic [COEF_W-1:0]       I_COEF_DATA;
    logic                    run;           // Source enable
    ddc_in_s                 src;           // Source pins
    logic                    O_CIC_VALID;
    logic [CHAN_W-1:0]       O_CIC_CHANNEL;
    logic signed [SMP_W-1:0] O_CIC_SAMPLE;
    logic                    O_OUT_VALID;
    logic [CHAN_W-1:0]       O_OUT_CHANNEL;
    logic signed [SMP_W-1:0] O_OUT_SAMPLE;
    int                      failures;
    int                      checked;

    always #10 I_SYS_CLK = ~I_SYS_CLK;

    ddc_adc_source src_u (.i_clk(I_SYS_CLK), .i_run(run), .i_prim(PRIM), .i_div(DIV),
                          .o_stream(src));

    ddc_downconverter_top dut_u (
        .I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET),
        .I_PRIMARY_ANTENNA_SAMPLE(src.prim), .I_DIVERSITY_ANTENNA_SAMPLE(src.div),
        .I_INPUT_CHANNEL_INDEX(src.chan), .I_INPUT_SAMPLE_VALID(src.valid),
        .I_COEF_WRITE(I_COEF_WRITE), .I_COEF_ADDR(I_COEF_ADDR), .I_COEF_DATA(I_COEF_DATA),
        .O_CIC_VALID(O_CIC_VALID), .O_CIC_CHANNEL(O_CIC_CHANNEL),
        .O_CIC_SAMPLE(O_CIC_SAMPLE), .O_OUT_VALID(O_OUT_VALID),
        .O_OUT_CHANNEL(O_OUT_CHANNEL), .O_OUT_SAMPLE(O_OUT_SAMPLE));

    // --------------------
    // Shared tasks
    // --------------------
    task automatic check_eq(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Steps whole cycles, then settles just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge I_SYS_CLK);
        #2;
    endtask

    // Bounded wait for the start of a burst on either output
    task automatic wait_burst(input bit outs);
        int n;
        n = 0;
        while ((outs ? O_OUT_VALID : O_CIC_VALID) === 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        while ((outs ? O_OUT_VALID : O_CIC_VALID) !== 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        if (n >= 2000)
        begin
            failures++;
            $display("wrong value burst start expected 1 seen 0");
            report_and_stop();
        end
    endtask

    // Walks one burst of sixteen; DC gains g1, g2 in 15-fraction units
    task automatic check_burst(input bit outs, input longint g1, input longint g2);
        longint s;
        wait_burst(outs);
        for (int c = 0; c < 16; c++)
        begin
            // Elements 0 and 2 carry the primary antenna
            s = ((c % 8) < 4 ? longint'(PRIM) : longint'(DIV)) * 4;
            if (outs)
            begin
                s = (s * g1) >>> 15;
                s = (s * g2) >>> 15;
                check_eq("out channel", 16'(O_OUT_CHANNEL), 16'(c));
                check_eq("out sample", O_OUT_SAMPLE, 16'(s));
            end
            else
            begin
                check_eq("cic channel", 16'(O_CIC_CHANNEL), 16'(c));
                check_eq("cic sample", O_CIC_SAMPLE, 16'(s));
            end
            tick(1);
        end
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task automatic test_cic();
        int n;
        tick(1200);
        check_burst(1'b0, 0, 0);
        n = 0;
        while (O_CIC_VALID !== 1'b1 && n < 100)
        begin
            tick(1);
            n++;
        end
        check_eq("cic gap", 16'(n), 16'h0030);
        $display("test cic burst done");
    endtask

    // Centre-only default taps pass DC at 32767/32768 per stage
    task automatic test_fir_default();
        tick(12000);
        check_burst(1'b1, 32767, 32767);
        $display("test fir default done");
    endtask

    // First FIR outer tap alone proves symmetric pairing, second FIR centre tap set to half; 0x4a must be ignored
    task automatic test_coef();
        logic [7:0]  a[4] = '{8'h0a, 8'h00, 8'h3f, 8'h4a};
        logic [15:0] d[4] = '{16'h0000, 16'h2000, 16'h4000, 16'h7fff};
        for (int k = 0; k < 4; k++)
        begin
            I_COEF_WRITE = 1'b1;
            I_COEF_ADDR  = a[k];
            I_COEF_DATA  = d[k];
            tick(1);
        end
        I_COEF_WRITE = 1'b0;
        tick(10000);
        check_burst(1'b1, 16384, 16384);
        $display("test coefficient write done");
    endtask

    // Reset in mid-run must silence outputs and restart cleanly
    task automatic test_mid_reset();
        tick(500);
        I_RESET = 1'b1;
        tick(3);
        check_eq("cic valid", 16'(O_CIC_VALID), 16'h0000);
        check_eq("out valid", 16'(O_OUT_VALID), 16'h0000);
        I_RESET = 1'b0;
        wait_burst(1'b0);
        check_eq("restart channel", 16'(O_CIC_CHANNEL), 16'h0000);
        $display("test mid-run reset done");
    endtask

    // --------------------
    // Main sequence
    // --------------------
    initial
    begin
        I_SYS_CLK = 1'b0;
        I_RESET = 1'b0;
        I_COEF_WRITE = 1'b0;
        I_COEF_ADDR = 8'h00;
        I_COEF_DATA = 16'h0000;
        run = 1'b0;
        failures = 0;
        checked = 0;
        // Raise reset after time zero so no flop can miss the edge
        #2;
        I_RESET = 1'b1;
        tick(20);
        check_eq("reset cic valid", 16'(O_CIC_VALID), 16'h0000);
        check_eq("reset out valid", 16'(O_OUT_VALID), 16'h0000);
        $display("test reset state done");
        I_RESET = 1'b0;
        run = 1'b1;
        test_cic();
        test_fir_default();
        test_coef();
        test_mid_reset();
        report_and_stop();
    end
endmodule // tb_top
